/* File: src/host_signal_map.svh */
// clock rate and timing counts for the host signalling block
`ifndef HOST_SIGNAL_MAP_SVH
`define HOST_SIGNAL_MAP_SVH
`define CLOCK_HZ 200000000
`define GOOD_READ_LONG_MS 100
`define GOOD_READ_SHORT_MS 50
`define GOOD_READ_LONG_CYCLES ((`CLOCK_HZ / 1000) * `GOOD_READ_LONG_MS)
`define GOOD_READ_SHORT_CYCLES ((`CLOCK_HZ / 1000) * `GOOD_READ_SHORT_MS)
`define SLEEP_TIMEOUT_MS 1000
`define SLEEP_TIMEOUT_CYCLES ((`CLOCK_HZ / 1000) * `SLEEP_TIMEOUT_MS)
`define POWER_DOWN_TIMEOUT_MIN 10
`define POWER_DOWN_TIMEOUT_CYCLES (64'd60 * `CLOCK_HZ * `POWER_DOWN_TIMEOUT_MIN)
`define BOOT_CYCLES 16
`define FILTER_CYCLES 8
`define BEEP_PERIOD_CYCLES 16'h0C35
`define BEEP_HIGH_CYCLES 16'h061A
`endif

/* File: src/host_signal_pkg.sv */
// types shared by the host signalling block
package host_signal_pkg;
    typedef enum logic [6:0] {
        MODE_BOOT = 7'h01,
        MODE_OPERATING = 7'h02,
        MODE_IDLE = 7'h04,
        MODE_SLEEP = 7'h08,
        MODE_PRESENT = 7'h10,
        MODE_POWER_DOWN = 7'h20,
        MODE_SUSPEND = 7'h40
    } power_mode_t;

    typedef struct packed {
        logic scan_done;
        logic tx_busy;
        logic tasks_idle;
        logic object_seen;
        logic cmd_operate;
        logic cmd_sleep;
        logic cmd_power_down;
        logic usb_suspend;
        logic usb_resume;
        logic reboot;
    } engine_event_t;

    typedef struct packed {
        logic usb_variant;
        logic serial_emulation;
        logic short_good_read;
        logic cts_active_high;
        logic rts_active_high;
        logic presentation_enable;
    } engine_config_t;
endpackage

/* File: src/host_signal_power_mode_ctrl.sv */
// host pin signalling and power-mode control of the decode engine
`timescale 1ns/1ps
`include "host_signal_map.svh"

module host_signal_power_mode_ctrl #(
    parameter logic [31:0] GOOD_READ_LONG = 32'(`GOOD_READ_LONG_CYCLES),
    parameter logic [31:0] GOOD_READ_SHORT = 32'(`GOOD_READ_SHORT_CYCLES),
    parameter logic [31:0] SLEEP_TIMEOUT = 32'(`SLEEP_TIMEOUT_CYCLES),
    parameter logic [39:0] POWER_DOWN_TIMEOUT = 40'(`POWER_DOWN_TIMEOUT_CYCLES)
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // host pins
    input wire logic serial_polarity_select,
    input wire logic wake_in_n,
    input wire logic trigger_in_n,
    input wire logic cts_pin,
    output logic rts_pin,
    output logic rxd_pin_unused,
    output logic powered_off_indicator,
    output logic beeper_out,
    output logic beeper_out_en_n,
    output logic good_read_out,
    output logic good_read_out_en_n,
    // serial data toward the uart core
    input wire logic rxd_pin,
    output logic rxd_core,
    input wire logic txd_core,
    output logic txd_pin,
    input wire logic rts_core,
    output logic cts_core,
    // engine side
    input wire host_signal_pkg::engine_event_t events,
    input wire host_signal_pkg::engine_config_t config_bits,
    output host_signal_pkg::power_mode_t mode,
    output logic scan_active,
    output logic host_comm_enable
);
    import host_signal_pkg::*;

    // ==========================================
    // input synchronisers and glitch filters
    logic [1:0] trig_sync, wake_sync, pol_sync, rxd_sync, cts_sync;
    logic [3:0] trig_cnt, wake_cnt;
    logic trig_low, wake_low;
    wire trig_raw_low = ~trig_sync[1];
    wire wake_raw_low = ~wake_sync[1];

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            trig_sync <= 2'h3;
            wake_sync <= 2'h3;
            pol_sync <= 2'h0;
            rxd_sync <= 2'h0;
            cts_sync <= 2'h0;
        end else begin
            trig_sync <= {trig_sync[0], trigger_in_n};
            wake_sync <= {wake_sync[0], wake_in_n};
            pol_sync <= {pol_sync[0], serial_polarity_select};
            rxd_sync <= {rxd_sync[0], rxd_pin};
            cts_sync <= {cts_sync[0], cts_pin};
        end
    end

    // a level must hold FILTER_CYCLES before it counts; short spikes are dropped
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            trig_cnt <= 4'h0;
            wake_cnt <= 4'h0;
            trig_low <= 1'b0;
            wake_low <= 1'b0;
        end else begin
            if (trig_raw_low == trig_low) trig_cnt <= 4'h0;
            else if (trig_cnt == 4'(`FILTER_CYCLES - 1)) begin
                trig_low <= trig_raw_low;
                trig_cnt <= 4'h0;
            end else trig_cnt <= trig_cnt + 4'h1;
            if (wake_raw_low == wake_low) wake_cnt <= 4'h0;
            else if (wake_cnt == 4'(`FILTER_CYCLES - 1)) begin
                wake_low <= wake_raw_low;
                wake_cnt <= 4'h0;
            end else wake_cnt <= wake_cnt + 4'h1;
        end
    end

    // ==========================================
    // serial line polarity
    wire invert_data = pol_sync[1];
    wire next_rxd = rxd_sync[1] ^ invert_data;
    wire next_txd = txd_core ^ invert_data;
    wire next_cts = cts_sync[1] ^ ~config_bits.cts_active_high;
    wire next_rts = rts_core ^ ~config_bits.rts_active_high;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rxd_core <= 1'b0;
            txd_pin <= 1'b0;
            cts_core <= 1'b0;
            rts_pin <= 1'b0;
            rxd_pin_unused <= 1'b0;
        end else begin
            rxd_core <= next_rxd;
            txd_pin <= next_txd;
            cts_core <= next_cts;
            rts_pin <= next_rts;
            rxd_pin_unused <= 1'b0;
        end
    end

    // ==========================================
    // power mode machine
    power_mode_t next_mode;
    logic good_read;
    logic [31:0] sleep_cnt;
    logic [39:0] pd_cnt;
    logic [4:0] boot_cnt;
    wire serial_variant = ~config_bits.usb_variant;
    wire sleep_expired = (sleep_cnt == SLEEP_TIMEOUT - 32'h1);
    wire pd_expired = serial_variant && (pd_cnt == POWER_DOWN_TIMEOUT - 40'h1);
    wire boot_done = (boot_cnt == 5'(`BOOT_CYCLES - 1));
    wire wake_req = wake_low || trig_low;

    always_comb begin
        next_mode = mode;
        case (mode)
            MODE_BOOT: if (boot_done) next_mode = MODE_IDLE;
            MODE_OPERATING: begin
                if (events.cmd_power_down && serial_variant) next_mode = MODE_POWER_DOWN;
                else if (events.reboot) next_mode = MODE_BOOT;
                else if (events.cmd_sleep) next_mode = MODE_SLEEP;
                else if (events.tasks_idle && !trig_low && !good_read) next_mode = MODE_IDLE;
            end
            MODE_IDLE: begin
                if (trig_low || events.cmd_operate) next_mode = MODE_OPERATING;
                else if (events.cmd_power_down && serial_variant) next_mode = MODE_POWER_DOWN;
                else if (events.reboot) next_mode = MODE_BOOT;
                else if (events.cmd_sleep || sleep_expired) next_mode = MODE_SLEEP;
            end
            MODE_SLEEP, MODE_PRESENT: begin
                if (trig_low) next_mode = MODE_OPERATING;
                else if (mode == MODE_PRESENT && events.object_seen) next_mode = MODE_OPERATING;
                else if (wake_low) next_mode = MODE_IDLE;
                else if (mode == MODE_SLEEP && events.cmd_operate && !serial_variant) next_mode = MODE_OPERATING;
                else if (events.cmd_power_down && serial_variant) next_mode = MODE_POWER_DOWN;
                else if (mode == MODE_SLEEP && pd_expired) next_mode = MODE_POWER_DOWN;
                else if (mode == MODE_SLEEP && config_bits.presentation_enable) next_mode = MODE_PRESENT;
            end
            MODE_POWER_DOWN: if (wake_req) next_mode = MODE_BOOT;
            MODE_SUSPEND: if (events.usb_resume) next_mode = MODE_BOOT;
            default: next_mode = MODE_BOOT;
        endcase
        if (config_bits.usb_variant && events.usb_suspend) next_mode = MODE_SUSPEND;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            mode <= MODE_BOOT;
            boot_cnt <= 5'h0;
            sleep_cnt <= 32'h0;
            pd_cnt <= 40'h0;
        end else begin
            mode <= next_mode;
            boot_cnt <= (mode == MODE_BOOT && !boot_done) ? boot_cnt + 5'h1 : 5'h0;
            // both timeouts restart on every entry into their mode
            sleep_cnt <= (mode == MODE_IDLE && next_mode == MODE_IDLE) ? sleep_cnt + 32'h1 : 32'h0;
            pd_cnt <= (mode == MODE_SLEEP && next_mode == MODE_SLEEP) ? pd_cnt + 40'h1 : 40'h0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            powered_off_indicator <= 1'b1;
            scan_active <= 1'b0;
            host_comm_enable <= 1'b0;
        end else begin
            powered_off_indicator <= (next_mode == MODE_BOOT) || (next_mode == MODE_POWER_DOWN)
                || (next_mode == MODE_SUSPEND);
            scan_active <= (next_mode == MODE_OPERATING);
            host_comm_enable <= (next_mode == MODE_IDLE) || (next_mode == MODE_OPERATING)
                || (config_bits.usb_variant && config_bits.serial_emulation
                    && (next_mode == MODE_SLEEP || next_mode == MODE_PRESENT));
        end
    end

    // ==========================================
    // good-read and beeper
    // the trigger level is the host's to hold until good-read; nothing here waits on it
    logic [31:0] gr_cnt;
    logic [15:0] pwm_cnt;
    wire [31:0] gr_min = config_bits.short_good_read ? GOOD_READ_SHORT : GOOD_READ_LONG;
    wire gr_min_done = (gr_cnt >= gr_min - 32'h1);
    wire pwm_high = (pwm_cnt < `BEEP_HIGH_CYCLES);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            good_read <= 1'b0;
            gr_cnt <= 32'h0;
            pwm_cnt <= 16'h0;
        end else begin
            if (events.scan_done && mode == MODE_OPERATING) begin
                good_read <= 1'b1;
                gr_cnt <= 32'h0;
            end else if (good_read) begin
                if (gr_min_done && !events.tx_busy) good_read <= 1'b0;
                if (!gr_min_done) gr_cnt <= gr_cnt + 32'h1;
            end
            pwm_cnt <= (!good_read || pwm_cnt == `BEEP_PERIOD_CYCLES - 16'h1) ? 16'h0 : pwm_cnt + 16'h1;
        end
    end

    // open drain: output value is always low, the enable decides; low enable means driving
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            good_read_out <= 1'b0;
            good_read_out_en_n <= 1'b1;
            beeper_out <= 1'b0;
            beeper_out_en_n <= 1'b1;
        end else begin
            good_read_out <= 1'b0;
            good_read_out_en_n <= ~good_read;
            beeper_out <= 1'b0;
            beeper_out_en_n <= ~(good_read && pwm_high);
        end
    end

    // ==========================================
    // checks
    chk_powered_off_indicator_mode: assert property (@(posedge clock) disable iff (!rst_n)
        ##1 powered_off_indicator == ($past(next_mode) inside {MODE_BOOT, MODE_POWER_DOWN, MODE_SUSPEND}))
        else $error("power-down indicator disagrees with mode");
    chk_mode_onehot: assert property (@(posedge clock) disable iff (!rst_n) $onehot(mode))
        else $error("power mode not one-hot");
    chk_trig_operate: assert property (@(posedge clock) disable iff (!rst_n)
        (mode inside {MODE_SLEEP, MODE_PRESENT, MODE_IDLE}) && trig_low && !(config_bits.usb_variant
        && events.usb_suspend) |=> mode == MODE_OPERATING)
        else $error("trigger did not reach operating");
    chk_wake_idle: assert property (@(posedge clock) disable iff (!rst_n)
        mode == MODE_SLEEP && wake_low && !trig_low && !(config_bits.usb_variant && events.usb_suspend)
        |=> mode == MODE_IDLE)
        else $error("wake did not reach idle");
    chk_pd_restart: assert property (@(posedge clock) disable iff (!rst_n)
        mode == MODE_POWER_DOWN && wake_req && !(config_bits.usb_variant && events.usb_suspend)
        |=> mode == MODE_BOOT)
        else $error("power down did not restart");
    chk_gr_min: assert property (@(posedge clock) disable iff (!rst_n)
        good_read && !gr_min_done |=> good_read)
        else $error("good-read released before minimum");
    chk_beep_pair: assert property (@(posedge clock) disable iff (!rst_n)
        good_read_out_en_n |-> beeper_out_en_n)
        else $error("beeper active without good-read");
    chk_filter_glitch: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(trig_low) |-> $past(trig_raw_low, 8))
        else $error("trigger accepted without filtering");
    chk_polarity: assert property (@(posedge clock) disable iff (!rst_n)
        $past(rst_n) |-> txd_pin == ($past(txd_core) ^ $past(invert_data)))
        else $error("transmit polarity wrong");
    chk_wake_filter: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(wake_low) |-> $past(wake_raw_low, 8))
        else $error("wake accepted without filtering");
    chk_sleep_restart: assert property (@(posedge clock) disable iff (!rst_n)
        mode == MODE_IDLE && $past(mode) != MODE_IDLE |-> sleep_cnt == 32'h0)
        else $error("sleep timeout not restarted on idle entry");
    chk_pd_timer_restart: assert property (@(posedge clock) disable iff (!rst_n)
        mode == MODE_SLEEP && $past(mode) != MODE_SLEEP |-> pd_cnt == 40'h0)
        else $error("power-down timeout not restarted on sleep entry");
    chk_comm_emulation: assert property (@(posedge clock) disable iff (!rst_n)
        $past(config_bits.usb_variant && config_bits.serial_emulation) && mode inside {MODE_SLEEP, MODE_PRESENT}
        |-> host_comm_enable)
        else $error("host link closed during sleep with serial emulation");
    chk_od_release: assert property (@(posedge clock) disable iff (!rst_n)
        !good_read |=> good_read_out_en_n && beeper_out_en_n)
        else $error("open-drain output driven while inactive");
    chk_scan_mode: assert property (@(posedge clock) disable iff (!rst_n)
        scan_active == (mode == MODE_OPERATING))
        else $error("scan active disagrees with operating mode");
    chk_pd_serial_only: assert property (@(posedge clock) disable iff (!rst_n)
        $past(config_bits.usb_variant) && $past(mode) != MODE_POWER_DOWN |-> mode != MODE_POWER_DOWN)
        else $error("power down entered in usb variant");
    chk_suspend_usb_only: assert property (@(posedge clock) disable iff (!rst_n)
        !$past(config_bits.usb_variant) && $past(mode) != MODE_SUSPEND |-> mode != MODE_SUSPEND)
        else $error("suspend entered in serial variant");
endmodule // host_signal_power_mode_ctrl

/* File: testbench/host_model.sv */
// host controller model that drives the trigger and wake pins
`timescale 1ns/1ps
module host_model #(
    parameter int BLANK_CYCLES = 32
) (
    // clock
    input wire logic clock,
    // requests from the bench
    input wire logic trig_req,
    input wire logic wake_req,
    // device pins
    input wire logic good_read_en_n,
    input wire logic powered_off_indicator,
    output logic trigger_in_n,
    output logic wake_in_n,
    output logic indicator_seen
);
    logic seen_good = 1'b0;
    int blank = 0;
    // =====================================
    // trigger and wake drivers
    always_ff @(posedge clock) begin
        if (!trig_req) seen_good <= 1'b0;
        else if (good_read_en_n === 1'b0) seen_good <= 1'b1;
    end
    // multi-try: trigger held low until good-read shows
    assign trigger_in_n = !(trig_req && !seen_good && good_read_en_n !== 1'b0);
    assign wake_in_n = !wake_req;
    // =====================================
    // indicator is not trusted until the blanking time after power-up
    always_ff @(posedge clock) begin
        if (blank < BLANK_CYCLES) blank <= blank + 1;
    end
    assign indicator_seen = (blank >= BLANK_CYCLES) && powered_off_indicator;
endmodule // host_model

/* File: testbench/tb_host_signal_power_mode_ctrl.sv */
// self-checking bench for the host signalling and power-mode block
`timescale 1ns/1ps
module tb_host_signal_power_mode_ctrl;
    import host_signal_pkg::*;
    localparam int GR_LONG = 100;
    localparam int GR_SHORT = 50;
    localparam int SLEEP_T = 200;
    localparam int PD_T = 300;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic pol = 1'b0, rxd_pin = 1'b1, txd_core = 1'b1, cts_pin = 1'b1, rts_core = 1'b1;
    logic trig_req = 1'b0, wake_req = 1'b0;
    engine_event_t ev = '0;
    engine_config_t cfg = '0;
    logic rts_pin, powered_off_indicator, beeper_out, beeper_out_en_n, good_read_out, good_read_out_en_n;
    logic rxd_core, txd_pin, cts_core, scan_active, host_comm_enable, trigger_in_n, wake_in_n, seen, unused_out;
    power_mode_t mode;
    int num_errors = 0;
    int n_compared = 0;
    int cycles = 0;
    int c;
    time t0;
    host_signal_power_mode_ctrl #(.GOOD_READ_LONG(32'd100), .GOOD_READ_SHORT(32'd50),
        .SLEEP_TIMEOUT(32'd200), .POWER_DOWN_TIMEOUT(40'd300)) dut (.clock(clock), .rst_n(rst_n),
        .serial_polarity_select(pol), .wake_in_n(wake_in_n), .trigger_in_n(trigger_in_n),
        .cts_pin(cts_pin), .rts_pin(rts_pin), .rxd_pin_unused(unused_out),
        .powered_off_indicator(powered_off_indicator),
        .beeper_out(beeper_out), .beeper_out_en_n(beeper_out_en_n), .good_read_out(good_read_out),
        .good_read_out_en_n(good_read_out_en_n), .rxd_pin(rxd_pin), .rxd_core(rxd_core), .txd_core(txd_core),
        .txd_pin(txd_pin), .rts_core(rts_core), .cts_core(cts_core), .events(ev), .config_bits(cfg),
        .mode(mode), .scan_active(scan_active), .host_comm_enable(host_comm_enable));
    host_model host (.clock(clock), .trig_req(trig_req), .wake_req(wake_req),
        .good_read_en_n(good_read_out_en_n), .powered_off_indicator(powered_off_indicator),
        .trigger_in_n(trigger_in_n), .wake_in_n(wake_in_n), .indicator_seen(seen));
    // =====================================
    // clock, timeout and helpers
    initial begin
        forever #2.5 clock = ~clock;
    end
    always @(negedge clock) begin
        cycles++;
        if (rst_n === 1'b1) check($onehot(mode), 1);
        if (cycles == 20000) begin
            num_errors++;
            complete_run();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    // sample one step after the edge so the design's updates have landed
    task automatic tick(input int n = 1);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic wait_mode(input power_mode_t m, input int lim);
        int n;
        n = 0;
        while (mode !== m && n < lim) begin
            tick();
            n++;
        end
        check(mode, m);
    endtask
    task automatic complete_run();
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // =====================================
    // test sequence
    initial begin
        ev.tasks_idle <= 1'b1;
        tick(20);
        @(posedge clock) rst_n <= 1'b1;
        tick();
        check({mode, powered_off_indicator}, {MODE_BOOT, 1'b1});
        wait_mode(MODE_IDLE, 30);
        t0 = $time;
        check({powered_off_indicator, host_comm_enable}, 2'b01);
        for (int i = 0; i < 16; i++) begin
            @(posedge clock);
            pol <= i[0];
            {rxd_pin, txd_core, cts_pin, rts_core} <= {4{i[1]}};
            {cfg.cts_active_high, cfg.rts_active_high} <= {i[2], i[3]};
            tick(5);
            check({rxd_core, txd_pin}, {2{i[1] ^ i[0]}});
            check({cts_core, rts_pin}, {i[1] ^ ~i[2], i[1] ^ ~i[3]});
        end
        wait_mode(MODE_SLEEP, SLEEP_T);
        c = int'(($time - t0) / 5);
        check(c >= SLEEP_T - 4 && c <= SLEEP_T + 6, 1);
        check({host_comm_enable, powered_off_indicator}, 2'b00);
        // a wake pulse shorter than the filter must not wake the engine
        @(posedge clock) wake_req <= 1'b1;
        tick(4);
        @(posedge clock) wake_req <= 1'b0;
        tick(20);
        check(mode, MODE_SLEEP);
        wait_mode(MODE_POWER_DOWN, PD_T + 20);
        check({powered_off_indicator, seen}, 2'b11);
        @(posedge clock) wake_req <= 1'b1;
        wait_mode(MODE_BOOT, 30);
        check(powered_off_indicator, 1);
        wait_mode(MODE_IDLE, 30);
        @(posedge clock) wake_req <= 1'b0;
        wait_mode(MODE_SLEEP, SLEEP_T + 60);
        @(posedge clock) trig_req <= 1'b1;
        c = 0;
        while (mode === MODE_SLEEP && c < 30) begin
            tick();
            c++;
        end
        check({mode, scan_active}, {MODE_OPERATING, 1'b1});
        // long, short and transmit-extended good-read intervals
        for (int k = 0; k < 3; k++) begin
            @(posedge clock) trig_req <= 1'b1;
            cfg.short_good_read <= (k == 1);
            wait_mode(MODE_OPERATING, 40);
            @(posedge clock) ev.scan_done <= 1'b1;
            ev.tx_busy <= (k == 2);
            @(posedge clock) ev.scan_done <= 1'b0;
            c = 0;
            while (good_read_out_en_n !== 1'b0 && c < 10) begin
                tick();
                c++;
            end
            check({good_read_out_en_n, beeper_out_en_n}, 2'b00);
            c = 0;
            while (good_read_out_en_n === 1'b0 && c < 400) begin
                check({good_read_out, beeper_out}, 2'b00);
                @(posedge clock);
                if (c >= 150) ev.tx_busy <= 1'b0;
                #1;
                c++;
            end
            check(beeper_out_en_n, 1);
            if (k == 2) check(c >= 150 && c <= 158, 1);
            else check(c >= (k == 1 ? GR_SHORT : GR_LONG) && c <= (k == 1 ? GR_SHORT : GR_LONG) + 4, 1);
            @(posedge clock) trig_req <= 1'b0;
            wait_mode(MODE_IDLE, 60);
        end
        // scan completion outside operating is refused
        @(posedge clock) ev.scan_done <= 1'b1;
        @(posedge clock) ev.scan_done <= 1'b0;
        tick(10);
        check(good_read_out_en_n, 1);
        // usb variant with serial emulation: link stays open asleep, suspend overrides
        @(posedge clock) {cfg.usb_variant, cfg.serial_emulation} <= 2'b11;
        ev.cmd_sleep <= 1'b1;
        wait_mode(MODE_SLEEP, 4);
        check({host_comm_enable, powered_off_indicator}, 2'b10);
        @(posedge clock) ev.cmd_sleep <= 1'b0;
        cfg.presentation_enable <= 1'b1;
        wait_mode(MODE_PRESENT, 4);
        check(host_comm_enable, 1);
        @(posedge clock) ev.object_seen <= 1'b1;
        wait_mode(MODE_OPERATING, 4);
        check(scan_active, 1);
        @(posedge clock) ev.object_seen <= 1'b0;
        ev.usb_suspend <= 1'b1;
        wait_mode(MODE_SUSPEND, 4);
        check({powered_off_indicator, host_comm_enable}, 2'b10);
        @(posedge clock) ev.usb_suspend <= 1'b0;
        ev.usb_resume <= 1'b1;
        wait_mode(MODE_BOOT, 4);
        check(powered_off_indicator, 1);
        @(posedge clock) ev.usb_resume <= 1'b0;
        wait_mode(MODE_IDLE, 30);
        check(unused_out, 0);
        complete_run();
    end
endmodule // tb_host_signal_power_mode_ctrl
